// [fslc_pkg.sv]
package fslc_pkg;

    // ----------------------------------------------------------------
    // Clock and bus timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WE_PULSE_NS = 100;
    localparam int T_READ_ACC_NS = 150;
    localparam int WE_PULSE_CYC  = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACC_CYC  = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC      = 3;
    localparam int READ_WAIT_CYC = READ_ACC_CYC + SYNC_CYC;
    localparam int CNT_W         = 4;

    // ----------------------------------------------------------------
    // Status register bit positions
    // ----------------------------------------------------------------
    localparam int MACHINE_READY_BIT     = 7;
    localparam int ERASE_CLEAR_ERROR_BIT = 5;
    localparam int PROGRAM_SET_ERROR_BIT = 4;
    localparam int PROGRAM_VOLT_LOW_BIT  = 3;
    localparam int PROGRAM_SUSPEND_BIT   = 2;
    localparam int DEVICE_PROTECT_BIT    = 1;

    localparam logic [7:0] SET_ERR_MASK   = 8'h3A;
    localparam logic [7:0] CLEAR_ERR_MASK = 8'h2A;
    localparam logic [7:0] PROG_ERR_MASK  = 8'h1A;

    // ----------------------------------------------------------------
    // Reset/power-down pin level request
    // ----------------------------------------------------------------
    localparam logic [1:0] RP_RESET_ACTIVE = 2'h0;
    localparam logic [1:0] RP_NORMAL_HIGH  = 2'h1;
    localparam logic [1:0] RP_OVERRIDE     = 2'h2;
    localparam logic [1:0] RP_RESET_VALUE  = RP_NORMAL_HIGH;

    // ----------------------------------------------------------------
    // User operations and carriers
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ_ARRAY  = 4'h0,
        OP_READ_STATUS = 4'h1,
        OP_CLEAR_STAT  = 4'h2,
        OP_PROGRAM     = 4'h3,
        OP_SUSPEND     = 4'h4,
        OP_RESUME      = 4'h5,
        OP_SET_BLOCK   = 4'h6,
        OP_SET_MASTER  = 4'h7,
        OP_CLEAR_LOCKS = 4'h8
    } fslc_op_t;

    typedef struct packed {
        fslc_op_t    op;
        logic [19:0] addr;
        logic [7:0]  data;
    } fslc_cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] rdata;
        logic       error;
    } fslc_result_t;

endpackage

// [fslc_host.sv]
// Notes on behaviour
// - While suspended only read-array elsewhere, read-status and resume are issued.
// - Host holds program voltage and reset pin level during program suspend.
// - Setting a protection bit is a setup write then a confirm write.
// - Host checks program/set error after set-protection and clears status if set.
// - Clear-protection is two writes; host then polls and inspects erase/clear error.
// - Clear aborted by supply or reset-pin change leaves bits undefined; host repeats it.
// - Host starts no lock operation while reset pin level is unsettled.
`timescale 1ns/1ps
module fslc_host #(
    parameter int         AW           = 20,
    parameter logic [7:0] CODE_RD_ARR  = 8'hFF,
    parameter logic [7:0] CODE_RD_STAT = 8'h70,
    parameter logic [7:0] CODE_CLR_ST  = 8'h50,
    parameter logic [7:0] CODE_PROG    = 8'h40,
    parameter logic [7:0] CODE_SUSP    = 8'hB0,
    parameter logic [7:0] CODE_RESUME  = 8'hD0,
    parameter logic [7:0] CODE_LOCK    = 8'h60,
    parameter logic [7:0] CODE_BLK_CNF = 8'h01,
    parameter logic [7:0] CODE_MST_CNF = 8'hF1,
    parameter logic [7:0] CODE_CLR_CNF = 8'hD0
) (
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    input  wire logic                  CMD_VALID,
    input  wire fslc_pkg::fslc_cmd_t   CMD,
    input  wire logic [1:0]            REQ_RP_LEVEL,
    input  wire logic                  REQ_VPP_EN,
    output logic                       CMD_READY,
    output logic                       CMD_REJECT,
    output logic                       DONE,
    output fslc_pkg::fslc_result_t     RESULT,
    output logic                       SUSPENDED,
    output logic                       LOCKS_UNKNOWN,
    output logic [AW-1:0]              ADDR,
    output logic [7:0]                 DQ_OUT,
    output logic                       DQ_OE,
    input  wire logic [7:0]            DQ_IN,
    output logic                       CE_N,
    output logic                       WE_N,
    output logic                       OE_N,
    output logic [1:0]                 RP_LEVEL,
    output logic                       VPP_EN,
    input  wire logic                  READY_BUSY_IN,
    input  wire logic                  VPP_OK,
    input  wire logic                  RP_STABLE
);

    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_WSET  = 4'h1,
        S_WPUL  = 4'h2,
        S_WREC  = 4'h3,
        S_POLL  = 4'h4,
        S_RPUL  = 4'h5,
        S_RSMP  = 4'h6,
        S_CHECK = 4'h7,
        S_DONE  = 4'h8
    } fslc_state_t;

    // ----------------------------------------------------------------
    // Operation decode
    // ----------------------------------------------------------------
    function automatic logic [7:0] first_code(input fslc_pkg::fslc_op_t op);
        case (op)
            fslc_pkg::OP_READ_ARRAY:  first_code = CODE_RD_ARR;
            fslc_pkg::OP_READ_STATUS: first_code = CODE_RD_STAT;
            fslc_pkg::OP_CLEAR_STAT:  first_code = CODE_CLR_ST;
            fslc_pkg::OP_PROGRAM:     first_code = CODE_PROG;
            fslc_pkg::OP_SUSPEND:     first_code = CODE_SUSP;
            fslc_pkg::OP_RESUME:      first_code = CODE_RESUME;
            default:                  first_code = CODE_LOCK;
        endcase
    endfunction

    function automatic logic two_writes(input fslc_pkg::fslc_op_t op);
        two_writes = (op == fslc_pkg::OP_PROGRAM) || (op == fslc_pkg::OP_SET_BLOCK) ||
                     (op == fslc_pkg::OP_SET_MASTER) || (op == fslc_pkg::OP_CLEAR_LOCKS);
    endfunction

    function automatic logic is_lock_op(input fslc_pkg::fslc_op_t op);
        is_lock_op = (op == fslc_pkg::OP_SET_BLOCK) || (op == fslc_pkg::OP_SET_MASTER) ||
                     (op == fslc_pkg::OP_CLEAR_LOCKS);
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    fslc_state_t          state;
    localparam int        CNT_W_L = fslc_pkg::CNT_W;
    fslc_pkg::fslc_cmd_t  cur;
    logic [CNT_W_L-1:0]   cnt;
    logic                 second;
    logic                 clearing;
    logic                 abort_seen;
    logic                 retry_pend;
    logic [AW-1:0]        prog_addr;
    logic [10:0]          s1, s2, s3, pin_f;

    // ----------------------------------------------------------------
    // Pin synchronisers: a change counts once stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        s1    <= {DQ_IN, READY_BUSY_IN, VPP_OK, RP_STABLE};
        s2    <= s1;
        s3    <= s2;
        pin_f <= (s2 & s3) | (pin_f & (s2 | s3));
    end

    wire logic [7:0] dq_f      = pin_f[10:3];
    wire logic       ready_f   = pin_f[2];
    wire logic       vpp_ok_f  = pin_f[1];
    wire logic       rp_stab_f = pin_f[0];

    // ----------------------------------------------------------------
    // Command admission
    // ----------------------------------------------------------------
    wire logic rp_settled = rp_stab_f && ((RP_LEVEL == fslc_pkg::RP_NORMAL_HIGH) ||
                                          (RP_LEVEL == fslc_pkg::RP_OVERRIDE));
    wire logic susp_ok    = (CMD.op == fslc_pkg::OP_READ_STATUS) || (CMD.op == fslc_pkg::OP_RESUME) ||
                            ((CMD.op == fslc_pkg::OP_READ_ARRAY) && (CMD.addr != prog_addr));
    wire logic lock_ok    = !is_lock_op(CMD.op) || rp_settled;
    wire logic allowed    = (RP_LEVEL != fslc_pkg::RP_RESET_ACTIVE) && (SUSPENDED ? susp_ok : lock_ok);
    wire logic take       = (state == S_IDLE) && CMD_VALID && !retry_pend && allowed;
    wire logic refuse     = (state == S_IDLE) && CMD_VALID && !retry_pend && !allowed;
    wire logic restart    = (state == S_IDLE) && retry_pend && vpp_ok_f && rp_settled;
    wire logic hold_pins  = SUSPENDED || (state != S_IDLE) || retry_pend;

    wire logic [7:0] second_byte = (cur.op == fslc_pkg::OP_PROGRAM)    ? cur.data :
                                   (cur.op == fslc_pkg::OP_SET_BLOCK)  ? CODE_BLK_CNF :
                                   (cur.op == fslc_pkg::OP_SET_MASTER) ? CODE_MST_CNF : CODE_CLR_CNF;
    wire logic [7:0] wr_byte     = clearing ? CODE_CLR_ST : (second ? second_byte : first_code(cur.op));
    wire logic       more_write  = !clearing && !second && two_writes(cur.op);
    wire logic       want_read   = (cur.op == fslc_pkg::OP_READ_ARRAY) || (cur.op == fslc_pkg::OP_READ_STATUS);
    wire logic       want_poll   = two_writes(cur.op) || (cur.op == fslc_pkg::OP_SUSPEND);
    wire logic [7:0] err_mask    = (cur.op == fslc_pkg::OP_CLEAR_LOCKS) ? fslc_pkg::CLEAR_ERR_MASK :
                                   (cur.op == fslc_pkg::OP_PROGRAM)     ? fslc_pkg::PROG_ERR_MASK :
                                   (cur.op == fslc_pkg::OP_SUSPEND)     ? 8'h00 : fslc_pkg::SET_ERR_MASK;
    wire logic       has_error   = (RESULT.status & err_mask) != 8'h00;
    wire logic       lost_supply = !vpp_ok_f || !rp_stab_f;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state         <= S_IDLE;
            cur           <= '0;
            cnt           <= '0;
            second        <= 1'b0;
            clearing      <= 1'b0;
            abort_seen    <= 1'b0;
            retry_pend    <= 1'b0;
            prog_addr     <= '0;
            CMD_READY     <= 1'b0;
            CMD_REJECT    <= 1'b0;
            DONE          <= 1'b0;
            RESULT        <= '0;
            SUSPENDED     <= 1'b0;
            LOCKS_UNKNOWN <= 1'b0;
            ADDR          <= '0;
            DQ_OUT        <= 8'h00;
            DQ_OE         <= 1'b0;
            CE_N          <= 1'b1;
            WE_N          <= 1'b1;
            OE_N          <= 1'b1;
            RP_LEVEL      <= fslc_pkg::RP_RESET_VALUE;
            VPP_EN        <= 1'b0;
        end else begin
            DONE       <= 1'b0;
            CMD_REJECT <= refuse;
            if (!hold_pins) begin
                RP_LEVEL <= REQ_RP_LEVEL;
                VPP_EN   <= REQ_VPP_EN;
            end
            if ((state != S_IDLE) && (cur.op == fslc_pkg::OP_CLEAR_LOCKS) && lost_supply) begin
                abort_seen <= 1'b1;
            end
            case (state)
                S_IDLE: begin
                    CMD_READY <= !retry_pend && !take && !restart;
                    second    <= 1'b0;
                    clearing  <= 1'b0;
                    if (take) begin
                        cur       <= CMD;
                        CMD_READY <= 1'b0;
                        state     <= S_WSET;
                        if (CMD.op == fslc_pkg::OP_PROGRAM) begin
                            prog_addr <= CMD.addr[AW-1:0];
                        end
                        if (CMD.op == fslc_pkg::OP_RESUME) begin
                            SUSPENDED <= 1'b0;
                        end
                    end else if (restart) begin
                        abort_seen <= 1'b0;
                        state      <= S_WSET;
                    end
                end
                S_WSET: begin
                    ADDR   <= cur.addr[AW-1:0];
                    DQ_OUT <= wr_byte;
                    DQ_OE  <= 1'b1;
                    CE_N   <= 1'b0;
                    cnt    <= CNT_W_L'(fslc_pkg::WE_PULSE_CYC);
                    state  <= S_WPUL;
                end
                S_WPUL: begin
                    WE_N <= 1'b0;
                    cnt  <= cnt - 1'b1;
                    if (cnt == CNT_W_L'(1)) begin
                        state <= S_WREC;
                    end
                end
                S_WREC: begin
                    WE_N  <= 1'b1;
                    CE_N  <= 1'b1;
                    DQ_OE <= 1'b0;
                    if (clearing) begin
                        state <= S_DONE;
                    end else if (more_write) begin
                        second <= 1'b1;
                        state  <= S_WSET;
                    end else if (want_read) begin
                        state <= S_RPUL;
                    end else if (want_poll) begin
                        state <= S_POLL;
                    end else begin
                        state <= S_DONE;
                    end
                end
                S_POLL: begin
                    if (ready_f) begin
                        state <= S_RPUL;
                    end
                end
                S_RPUL: begin
                    CE_N  <= 1'b0;
                    OE_N  <= 1'b0;
                    cnt   <= CNT_W_L'(fslc_pkg::READ_WAIT_CYC);
                    state <= S_RSMP;
                end
                S_RSMP: begin
                    cnt <= cnt - 1'b1;
                    if (cnt == CNT_W_L'(1)) begin
                        CE_N <= 1'b1;
                        OE_N <= 1'b1;
                        if (want_read) begin
                            RESULT.rdata <= dq_f;
                            if (cur.op == fslc_pkg::OP_READ_STATUS) begin
                                RESULT.status <= dq_f;
                            end
                            state <= S_DONE;
                        end else begin
                            RESULT.status <= dq_f;
                            state <= dq_f[fslc_pkg::MACHINE_READY_BIT] ? S_CHECK : S_POLL;
                        end
                    end
                end
                S_CHECK: begin
                    if (cur.op == fslc_pkg::OP_SUSPEND) begin
                        SUSPENDED <= RESULT.status[fslc_pkg::PROGRAM_SUSPEND_BIT];
                    end
                    RESULT.error <= has_error;
                    if (has_error) begin
                        clearing <= 1'b1;
                        state    <= S_WSET;
                    end else begin
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    DONE <= 1'b1;
                    if (cur.op == fslc_pkg::OP_CLEAR_LOCKS) begin
                        retry_pend    <= abort_seen;
                        LOCKS_UNKNOWN <= abort_seen;
                    end
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // fslc_host

// [fslc_flash_model.sv]
`timescale 1ns/1ps
module fslc_flash_model (
    input  wire logic        CLK,
    input  wire logic [19:0] ADDR,
    input  wire logic [7:0]  DQ_OUT,
    output logic      [7:0]  DQ_IN,
    input  wire logic        CE_N,
    input  wire logic        WE_N,
    input  wire logic        OE_N,
    input  wire logic [1:0]  RP_LEVEL,
    input  wire logic        VPP_EN,
    output logic             READY_BUSY_IN,
    output logic             RP_STABLE
);
    logic [7:0]  mem [0:255];
    logic [15:0] blk_lock = 16'h0000;
    logic        master   = 1'b0;
    logic        smode    = 1'b0;
    logic        we_q     = 1'b1;
    logic [7:0]  stat     = 8'h00;
    logic [7:0]  pend     = 8'h00;
    logic [7:0]  last     = 8'h00;
    logic [1:0]  rp_q     = 2'h1;
    int          busy     = 0;
    int          settle   = 0;
    int          held     = 0;
    wire         ovr      = (RP_LEVEL == fslc_pkg::RP_OVERRIDE);
    wire         blocked  = blk_lock[ADDR[19:16]] && !ovr;
    wire         mlock    = master && !ovr;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // ------------------------------------------------
    // Command decode on the falling write strobe
    // ------------------------------------------------
    always @(posedge CLK) begin
        we_q <= WE_N;
        rp_q <= RP_LEVEL;
        settle <= (RP_LEVEL != rp_q) ? 3 : (settle > 0 ? settle - 1 : 0);
        busy <= (busy > 0) ? busy - 1 : 0;
        if (!CE_N && !OE_N) last <= DQ_IN;
        if (RP_LEVEL == fslc_pkg::RP_RESET_ACTIVE) begin
            pend <= 8'h00;
            smode <= 1'b0;
        end else if (!WE_N && we_q && !CE_N) begin
            pend <= 8'h00;
            smode <= 1'b1;
            busy <= (pend != 8'h00) ? 8 : 0;
            if (pend == 8'h40) begin
                stat <= stat | (blocked ? 8'h12 : 8'h00);
                if (!blocked) mem[ADDR[7:0]] <= DQ_OUT;
            end else if (pend == 8'h60) begin
                case (DQ_OUT)
                    8'h01: begin
                        stat <= stat | (mlock ? 8'h12 : 8'h00);
                        blk_lock[ADDR[19:16]] <= blk_lock[ADDR[19:16]] | !mlock;
                    end
                    8'hF1: begin
                        stat <= stat | (ovr ? 8'h00 : 8'h12);
                        master <= master | ovr;
                    end
                    8'hD0: begin
                        stat <= stat | (!VPP_EN ? 8'h28 : mlock ? 8'h22 : 8'h00);
                        blk_lock <= (VPP_EN && !mlock) ? 16'h0000 : blk_lock;
                    end
                    default: stat <= stat | 8'h30;
                endcase
            end else begin
                pend <= (DQ_OUT == 8'h40 || DQ_OUT == 8'h60) ? DQ_OUT : 8'h00;
                smode <= (DQ_OUT != 8'hFF);
                if (DQ_OUT == 8'h50) stat <= 8'h00;
                if (DQ_OUT == 8'hB0 && busy > 1) begin
                    held <= busy;
                    busy <= 3;
                    stat[2] <= 1'b1;
                end
                if (DQ_OUT == 8'hD0 && stat[2]) begin
                    busy <= held;
                    stat[2] <= 1'b0;
                end
            end
        end
    end
    assign READY_BUSY_IN = (busy == 0);
    assign RP_STABLE = (settle == 0);
    assign DQ_IN = (CE_N || OE_N) ? ~last : smode ? {busy == 0, stat[6:0]} : mem[ADDR[7:0]];
endmodule // fslc_flash_model

// [fslc_host_sva.sv]
`timescale 1ns/1ps
module fslc_host_sva (
    input wire logic                CLK,
    input wire logic                RESET,
    input wire logic                CMD_VALID,
    input wire fslc_pkg::fslc_cmd_t CMD,
    input wire logic                CMD_READY,
    input wire logic                CMD_REJECT,
    input wire logic                DONE,
    input wire logic                SUSPENDED,
    input wire logic [7:0]          DQ_OUT,
    input wire logic                DQ_OE,
    input wire logic                CE_N,
    input wire logic                WE_N,
    input wire logic                OE_N,
    input wire logic [1:0]          RP_LEVEL,
    input wire logic                VPP_EN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence take_s(fslc_pkg::fslc_op_t o);
        CMD_VALID && CMD_READY && CMD.op == o;
    endsequence
    sequence wr_s(logic [7:0] c);
        !WE_N && !CE_N && DQ_OE && DQ_OUT == c;
    endsequence
    property two_write_p(fslc_pkg::fslc_op_t o, logic [7:0] a, logic [7:0] b);
        take_s(o) ##1 !CMD_REJECT |-> ##[0:5] wr_s(a) ##[1:8] wr_s(b);
    endproperty
    reset_quiet_a: assert property ($fell(RESET) |-> CE_N && WE_N && OE_N && !DQ_OE && !CMD_READY)
        else $error("bus not quiet after reset");
    susp_gate_a: assert property (SUSPENDED && CMD_VALID && CMD_READY && !(CMD.op inside {fslc_pkg::OP_READ_ARRAY,
        fslc_pkg::OP_READ_STATUS, fslc_pkg::OP_RESUME}) |=> CMD_REJECT) else $error("command taken while suspended");
    rp_gate_a: assert property (CMD_VALID && CMD_READY && RP_LEVEL == fslc_pkg::RP_RESET_ACTIVE |=> CMD_REJECT)
        else $error("command taken in reset level");
    susp_hold_a: assert property (SUSPENDED && $past(SUSPENDED) |-> $stable(RP_LEVEL) && $stable(VPP_EN))
        else $error("levels moved while suspended");
    set_block_a: assert property (two_write_p(fslc_pkg::OP_SET_BLOCK, 8'h60, 8'h01))
        else $error("block set writes wrong");
    set_master_a: assert property (two_write_p(fslc_pkg::OP_SET_MASTER, 8'h60, 8'hF1))
        else $error("master set writes wrong");
    clear_locks_a: assert property (two_write_p(fslc_pkg::OP_CLEAR_LOCKS, 8'h60, 8'hD0))
        else $error("clear writes wrong");
    resume_write_a: assert property (take_s(fslc_pkg::OP_RESUME) ##1 !CMD_REJECT |-> ##[0:5] wr_s(8'hD0))
        else $error("resume write missing");
    answer_pulse_a: assert property ((DONE || CMD_REJECT) |=> !DONE && !CMD_REJECT)
        else $error("answer longer than one cycle");
    read_quiet_a: assert property (!OE_N |-> !DQ_OE && !CE_N && WE_N)
        else $error("drive during read");
endmodule // fslc_host_sva
bind fslc_host fslc_host_sva i_sva (.CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .CMD_REJECT(CMD_REJECT), .DONE(DONE), .SUSPENDED(SUSPENDED), .DQ_OUT(DQ_OUT),
    .DQ_OE(DQ_OE), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N), .RP_LEVEL(RP_LEVEL), .VPP_EN(VPP_EN));

// [fslc_host_tb.sv]
`timescale 1ns/1ps
module fslc_host_tb;
    logic                   CLK = 1'b0, RESET = 1'b1, CMD_VALID = 1'b0, REQ_VPP_EN = 1'b1, VPP_OK = 1'b1;
    fslc_pkg::fslc_cmd_t    CMD = '0;
    logic [1:0]             REQ_RP_LEVEL = fslc_pkg::RP_NORMAL_HIGH;
    logic                   CMD_READY, CMD_REJECT, DONE, SUSPENDED, LOCKS_UNKNOWN, DQ_OE, CE_N, WE_N, OE_N, VPP_EN;
    logic                   READY_BUSY_IN, RP_STABLE;
    fslc_pkg::fslc_result_t RESULT;
    logic [19:0]            ADDR, a;
    logic [7:0]             DQ_OUT, DQ_IN, d;
    logic [1:0]             RP_LEVEL;
    logic [17:0]            exp_q[$], mask_q[$];
    int                     failures = 0, checks_done = 0, seed = 89;
    localparam logic [17:0] M_ST = {1'b1, 8'hBE, 8'h00, 1'b1};
    localparam logic [17:0] M_RD = {1'b1, 8'h00, 8'hFF, 1'b0};
    localparam logic [17:0] M_WO = {1'b1, 16'h0000, 1'b1};
    localparam logic [17:0] M_RJ = {1'b1, 17'h00000};
    always #50 CLK = ~CLK;
    fslc_host i_dut (.CLK(CLK), .RESET(RESET), .CMD_VALID(CMD_VALID), .CMD(CMD), .REQ_RP_LEVEL(REQ_RP_LEVEL),
        .REQ_VPP_EN(REQ_VPP_EN), .CMD_READY(CMD_READY), .CMD_REJECT(CMD_REJECT), .DONE(DONE), .RESULT(RESULT),
        .SUSPENDED(SUSPENDED), .LOCKS_UNKNOWN(LOCKS_UNKNOWN), .ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
        .DQ_IN(DQ_IN), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N), .RP_LEVEL(RP_LEVEL), .VPP_EN(VPP_EN),
        .READY_BUSY_IN(READY_BUSY_IN), .VPP_OK(VPP_OK), .RP_STABLE(RP_STABLE));
    fslc_flash_model i_flash (.CLK(CLK), .ADDR(ADDR), .DQ_OUT(DQ_OUT), .DQ_IN(DQ_IN), .CE_N(CE_N), .WE_N(WE_N),
        .OE_N(OE_N), .RP_LEVEL(RP_LEVEL), .VPP_EN(VPP_EN), .READY_BUSY_IN(READY_BUSY_IN), .RP_STABLE(RP_STABLE));
    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    function automatic logic [17:0] st(input logic [7:0] s, input logic e);
        return {1'b0, s, 8'h00, e};
    endfunction
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input fslc_pkg::fslc_op_t op, input logic [19:0] ad, input logic [7:0] dt,
                       input logic [17:0] m, input logic [17:0] e);
        while (CMD_READY !== 1'b1) @(posedge CLK) #1;
        mask_q.push_back(m);
        exp_q.push_back(e);
        @(posedge CLK);
        CMD_VALID <= 1'b1;
        CMD <= {op, ad, dt};
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        #1;
        while (DONE !== 1'b1 && CMD_REJECT !== 1'b1) @(posedge CLK) #1;
    endtask
    task automatic set_lv(input logic [1:0] lv, input logic vp);
        @(posedge CLK);
        REQ_RP_LEVEL <= lv;
        REQ_VPP_EN <= vp;
        repeat (12) @(posedge CLK);
    endtask
    // ------------------------------------------------
    // Result monitor
    // ------------------------------------------------
    always @(posedge CLK) begin
        if (DONE === 1'b1 || CMD_REJECT === 1'b1) begin
            if (exp_q.size() > 0) begin
                check({CMD_REJECT, RESULT} & mask_q[0], exp_q[0]);
                void'(exp_q.pop_front());
                void'(mask_q.pop_front());
            end else begin
                failures++;
            end
        end
    end
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        end_sim();
    end
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        repeat (8) @(posedge CLK);
        for (int i = 0; i < 4; i++) begin
            a = {12'h300, 8'($random(seed))};
            d = 8'($random(seed));
            run(fslc_pkg::OP_PROGRAM, a, d, M_ST, st(8'h80, 1'b0));
            run(fslc_pkg::OP_READ_ARRAY, a, 8'h00, M_RD, {9'h000, d, 1'b0});
        end
        run(fslc_pkg::OP_SET_BLOCK, 20'h10000, 8'h00, M_ST, st(8'h80, 1'b0));
        run(fslc_pkg::OP_PROGRAM, 20'h10011, 8'h3C, M_ST, st(8'h92, 1'b1));
        set_lv(fslc_pkg::RP_OVERRIDE, 1'b1);
        run(fslc_pkg::OP_PROGRAM, 20'h10022, 8'hA5, M_ST, st(8'h80, 1'b0));
        run(fslc_pkg::OP_READ_ARRAY, 20'h10022, 8'h00, M_RD, {9'h000, 8'hA5, 1'b0});
        run(fslc_pkg::OP_SET_MASTER, 20'h00000, 8'h00, M_ST, st(8'h80, 1'b0));
        set_lv(fslc_pkg::RP_NORMAL_HIGH, 1'b1);
        run(fslc_pkg::OP_SET_MASTER, 20'h00000, 8'h00, M_ST, st(8'h92, 1'b1));
        run(fslc_pkg::OP_SET_BLOCK, 20'h20000, 8'h00, M_ST, st(8'h92, 1'b1));
        run(fslc_pkg::OP_CLEAR_LOCKS, 20'h00000, 8'h00, M_ST, st(8'hA2, 1'b1));
        set_lv(fslc_pkg::RP_OVERRIDE, 1'b0);
        run(fslc_pkg::OP_CLEAR_LOCKS, 20'h00000, 8'h00, M_ST, st(8'hA8, 1'b1));
        set_lv(fslc_pkg::RP_OVERRIDE, 1'b1);
        run(fslc_pkg::OP_CLEAR_LOCKS, 20'h00000, 8'h00, M_ST, st(8'h80, 1'b0));
        fork
            run(fslc_pkg::OP_CLEAR_LOCKS, 20'h00000, 8'h00, M_ST, st(8'h80, 1'b0));
            begin
                repeat (4) @(posedge CLK);
                VPP_OK <= 1'b0;
                repeat (6) @(posedge CLK);
                VPP_OK <= 1'b1;
            end
        join
        check({17'h00000, LOCKS_UNKNOWN}, 18'h00001);
        mask_q.push_back(M_ST);
        exp_q.push_back(st(8'h80, 1'b0));
        do @(posedge CLK) #1; while (DONE !== 1'b1);
        check({17'h00000, LOCKS_UNKNOWN}, 18'h00000);
        set_lv(fslc_pkg::RP_NORMAL_HIGH, 1'b1);
        run(fslc_pkg::OP_PROGRAM, 20'h10033, 8'h5A, M_ST, st(8'h80, 1'b0));
        run(fslc_pkg::OP_SUSPEND, 20'h10033, 8'h00, {1'b1, 8'h84, 8'h00, 1'b1}, st(8'h80, 1'b0));
        check({17'h00000, SUSPENDED}, 18'h00000);
        run(fslc_pkg::OP_RESUME, 20'h10033, 8'h00, M_WO, 18'h00000);
        run(fslc_pkg::OP_CLEAR_STAT, 20'h00000, 8'h00, M_WO, 18'h00000);
        set_lv(fslc_pkg::RP_RESET_ACTIVE, 1'b1);
        run(fslc_pkg::OP_READ_STATUS, 20'h00000, 8'h00, M_RJ, M_RJ);
        set_lv(fslc_pkg::RP_NORMAL_HIGH, 1'b1);
        run(fslc_pkg::OP_READ_STATUS, 20'h00000, 8'h00, M_ST, st(8'h80, 1'b0));
        repeat (4) @(posedge CLK);
        end_sim();
    end
endmodule // fslc_host_tb
